//--- playback_cmd_map.svh
// Purpose: offsets, codes, bit positions and reset values
// Assumes: byte addresses on a 32-bit classic Wishbone
// Notes:   definitions only
`ifndef PLAYBACK_CMD_MAP_SVH
`define PLAYBACK_CMD_MAP_SVH
// command identifiers
`define CMD_SEL_STREAMS  16'h0213
`define CMD_VIDEO_FORMAT 16'h0305
`define CMD_WINDOW       16'h0606
`define CMD_STEP         16'h000b
`define CMD_SLOW         16'h0109
`define CMD_EVENT_ENABLE 16'h0104
// format codes
`define FMT_NO_REPEAT    16'h0000
`define FMT_PAL          16'h0003
`define FMT_NTSC         16'h0004
// event bit positions
`define EVT_RDY_S_BIT    10
`define EVT_END_P_BIT    13
// register byte offsets
`define REG_CMD          8'h00
`define REG_EVT_STATUS   8'h04
`define REG_EVT_MASK     8'h08
`define REG_VCONFIG      8'h0c
`define REG_STREAMS      8'h10
`define REG_FORMAT       8'h14
`define REG_HCOEFF       8'h18
`define REG_INTERLACE    8'h1c
// valid stream id ranges
`define VID_ID_LO        16'h00e0
`define VID_ID_HI        16'h00ef
`define AUD_ID_LO        16'h00c0
`define AUD_ID_HI        16'h00df
// reset values and argument limit
`define RST_VIDEO_ID     16'h00e0
`define RST_AUDIO_ID     16'h00c0
`define RST_VCONFIG      16'h0000
`define RST_MASK         16'h0000
`define RST_SLOW_N       4'h1
`define MAX_ARGS         6
`endif

//--- playback_cmd_pkg.sv
// Purpose: shared types of the command handler
// Assumes: nothing
// Notes:   constants live in playback_cmd_map.svh
`default_nettype none
package playback_cmd_pkg;
  typedef logic [15:0] word_t;
  typedef logic [5:0][15:0] args_t;
  typedef enum logic [1:0] {MODE_IDLE, MODE_STEP, MODE_PAUSED, MODE_SLOW} play_mode_e;
endpackage
`default_nettype wire

//--- cmd_if.sv
// Purpose: carries one complete command between modules
// Assumes: valid/ready handshake on clk_i
// Notes:   watch modport only observes
`default_nettype none
interface cmd_if;
  logic                    valid;
  logic                    ready;
  playback_cmd_pkg::word_t id;
  playback_cmd_pkg::args_t arg;
  modport source(output valid, output id, output arg, input ready);
  modport sink(input valid, input id, input arg, output ready);
  modport watch(input valid, input ready, input id, input arg);
endinterface
`default_nettype wire

//--- cmd_collector.sv
// Purpose: gathers a command word and its arguments
// Assumes: words pushed one at a time
// Notes:   arguments past six are counted, not stored
`default_nettype none
`include "playback_cmd_map.svh"
module cmd_collector (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        push_i,
  input  wire logic [15:0] word_i,
  output logic             accept_o,
  cmd_if.source            cmd
);
  logic       have_id;
  logic       full;
  logic [3:0] need;
  logic [3:0] idx;
  wire        take = push_i & ~full;
  wire [3:0]  word_need = word_i[11:8];
  wire        last_arg = (idx == need - 4'h1);

  assign accept_o  = ~full;
  assign cmd.valid = full;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      have_id <= 1'b0;
      full    <= 1'b0;
      need    <= 4'h0;
      idx     <= 4'h0;
      cmd.id  <= 16'h0000;
      cmd.arg <= '0;
    end else if (cmd.valid & cmd.ready) begin
      full <= 1'b0;
    end else if (take & ~have_id) begin
      cmd.id  <= word_i;
      need    <= word_need;
      idx     <= 4'h0;
      have_id <= (word_need != 4'h0);
      full    <= (word_need == 4'h0);
    end else if (take) begin
      if (idx < 4'(`MAX_ARGS)) cmd.arg[idx[2:0]] <= word_i;
      idx     <= idx + 4'h1;
      have_id <= ~last_arg;
      full    <= last_arg;
    end
  end
endmodule
`default_nettype wire

//--- window_shadow.sv
// Purpose: pending and active display window
// Assumes: vblank_rise_i is a one-cycle pulse
// Notes:   horizontal in 601 pixels, vertical in SIF lines
`default_nettype none
`include "playback_cmd_map.svh"
module window_shadow #(
  parameter logic [15:0] SCREEN_W = 16'd720,
  parameter logic [15:0] SCREEN_H = 16'd240
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  cmd_if.watch             cmd,
  input  wire logic        vblank_rise_i,
  input  wire logic [15:0] coded_w_i,
  input  wire logic [15:0] coded_h_i,
  output logic      [15:0] left_o,
  output logic      [15:0] top_o,
  output logic      [15:0] x_shift_o,
  output logic      [15:0] y_shift_o,
  output logic      [15:0] width_o,
  output logic      [15:0] height_o,
  output logic             pending_o
);
  playback_cmd_pkg::args_t pend;

  function automatic logic [15:0] centre(input logic [15:0] scr, input logic [15:0] sz);
    centre = (sz >= scr) ? 16'h0000 : 16'((scr - sz) >> 1);
  endfunction

  function automatic logic [15:0] pick(input logic [15:0] v, input logic [15:0] dflt);
    pick = (v == 16'h0000) ? dflt : v;
  endfunction

  wire        load   = cmd.valid & cmd.ready & (cmd.id == `CMD_WINDOW);
  wire [15:0] eff_w  = pick(pend[4], coded_w_i);
  wire [15:0] eff_h  = pick(pend[5], coded_h_i);
  wire [15:0] eff_l  = pick(pend[0], centre(SCREEN_W, eff_w));
  wire [15:0] eff_t  = pick(pend[1], centre(SCREEN_H, eff_h));
  wire        apply  = pending_o & vblank_rise_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend      <= '0;
      pending_o <= 1'b0;
    end else if (load) begin
      pend      <= cmd.arg;
      pending_o <= 1'b1;
    end else if (apply) begin
      pending_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_o    <= 16'h0000;
      top_o     <= 16'h0000;
      x_shift_o <= 16'h0000;
      y_shift_o <= 16'h0000;
      width_o   <= 16'h0000;
      height_o  <= 16'h0000;
    end else if (apply) begin
      left_o    <= eff_l;
      top_o     <= eff_t;
      x_shift_o <= pend[2];
      y_shift_o <= pend[3];
      width_o   <= eff_w;
      height_o  <= eff_h;
    end
  end
endmodule
`default_nettype wire

//--- playback_display_command_handler.sv
// Purpose: executes stream, format, window and play commands
// Assumes: single clock, synchronous reset, classic Wishbone
// Notes:   vblank_i is a pin and is synchronised
// Contract
// - stream command picks video and audio ids
// - selection gates output in every play mode
// - invalid id suppresses that stream's output
// - format code: 0 none, 3 PAL, 4 NTSC
// - horizontal coefficient zero disables interpolation
// - interlace selector zero gives progressive output
// - vertical interpolation from configuration register
// - window command takes six ordered arguments
// - zero margin centres the window
// - source shift pixel at window top-left
// - zero size uses coded picture size
// - window changes only after vertical blanking
// - horizontal in 601 pixels, vertical SIF lines
// - step decodes one picture, pauses, audio off
// - slow motion repeats each picture N frames
// - slow motion stops input when buffer full
// - below threshold re-enables input, data request
// - completion event bit 13, request bit 10
// - enabled events recorded, interrupt pin set
//
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`default_nettype none
`include "playback_cmd_map.svh"
module playback_display_command_handler #(
  parameter logic [15:0] SCREEN_W = 16'd720,
  parameter logic [15:0] SCREEN_H = 16'd240
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        vblank_i,
  input  wire logic        frame_tick_i,
  input  wire logic        picture_done_i,
  input  wire logic        buffer_full_i,
  input  wire logic        below_threshold_i,
  input  wire logic [15:0] coded_w_i,
  input  wire logic [15:0] coded_h_i,
  output logic      [15:0] video_stream_select_o,
  output logic      [15:0] audio_stream_select_o,
  output logic             video_out_en_o,
  output logic             audio_out_en_o,
  output logic      [15:0] format_code_o,
  output logic             field_repeat_en_o,
  output logic             pal_o,
  output logic             ntsc_o,
  output logic      [15:0] horiz_interp_coeff_o,
  output logic             horiz_interp_en_o,
  output logic             interlaced_o,
  output logic      [15:0] vert_interp_o,
  output logic      [15:0] left_margin_o,
  output logic      [15:0] top_margin_o,
  output logic      [15:0] source_x_shift_o,
  output logic      [15:0] source_y_shift_o,
  output logic      [15:0] window_width_o,
  output logic      [15:0] window_height_o,
  output logic             decode_next_o,
  output logic             bitstream_input_en_o,
  output logic             int_o
);
  cmd_if cmd ();

  playback_cmd_pkg::play_mode_e mode;
  playback_cmd_pkg::play_mode_e next_mode;

  logic [15:0] event_enable_mask;
  logic [15:0] event_status;
  logic [15:0] vconfig;
  logic [15:0] fmt;
  logic [15:0] hcoeff;
  logic [15:0] interlace_sel;
  logic [3:0]  slow_n;
  logic [3:0]  rep_cnt;
  logic        slow_in_en;
  logic        ack;
  logic        vb_meta;
  logic        vb_sync;
  logic        vb_last;
  logic        accept;
  logic        win_pending;

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] sel);
    merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  // bus decode
  wire        req      = wb_cyc_i & wb_stb_i;
  wire        at_cmd   = (wb_adr_i == `REG_CMD);
  wire        stall    = at_cmd & wb_we_i & ~accept;
  wire        fire     = req & ~ack & ~stall;
  wire        wr       = fire & wb_we_i;
  wire        rd       = fire & ~wb_we_i;
  wire        wr_cmd   = wr & at_cmd;
  wire        wr_clr   = wr & (wb_adr_i == `REG_EVT_STATUS);
  wire        wr_mask  = wr & (wb_adr_i == `REG_EVT_MASK);
  wire        wr_vcfg  = wr & (wb_adr_i == `REG_VCONFIG);
  wire [15:0] clr_bits = merge16(16'h0000, wb_dat_i[15:0], wb_sel_i[1:0]);

  // command execution
  wire        take     = cmd.valid & cmd.ready;
  wire        is_strm  = take & (cmd.id == `CMD_SEL_STREAMS);
  wire        is_fmt   = take & (cmd.id == `CMD_VIDEO_FORMAT);
  wire        is_mask  = take & (cmd.id == `CMD_EVENT_ENABLE);
  wire        is_step  = take & (cmd.id == `CMD_STEP);
  wire        is_slow  = take & (cmd.id == `CMD_SLOW);
  wire        in_step  = (mode == playback_cmd_pkg::MODE_STEP);
  wire        in_slow  = (mode == playback_cmd_pkg::MODE_SLOW);
  wire [3:0]  arg_n    = cmd.arg[0][3:0];
  wire [3:0]  n_eff    = (slow_n == 4'h0) ? 4'h1 : slow_n;
  wire        rep_done = (rep_cnt >= n_eff - 4'h1);
  wire        slow_adv = in_slow & frame_tick_i & rep_done;

  // events
  wire        step_end = in_step & picture_done_i;
  wire        slow_ful = in_slow & slow_in_en & buffer_full_i;
  wire        slow_rdy = in_slow & ~slow_in_en & below_threshold_i;
  wire [15:0] evt_raw  = (16'((step_end | slow_ful)) << `EVT_END_P_BIT) |
                         (16'(slow_rdy) << `EVT_RDY_S_BIT);
  wire [15:0] evt_on   = evt_raw & event_enable_mask;
  wire [15:0] next_evt = (event_status & ~(wr_clr ? clr_bits : 16'h0000)) | evt_on;

  // vertical blank edge
  wire        vb_rise  = vb_sync & ~vb_last;

  // queued behind a step still in progress
  assign cmd.ready = ~in_step;

  cmd_collector u_collect (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .push_i   (wr_cmd),
    .word_i   (merge16(16'h0000, wb_dat_i[15:0], wb_sel_i[1:0])),
    .accept_o (accept),
    .cmd      (cmd)
  );

  window_shadow #(
    .SCREEN_W (SCREEN_W),
    .SCREEN_H (SCREEN_H)
  ) u_window (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .cmd           (cmd),
    .vblank_rise_i (vb_rise),
    .coded_w_i     (coded_w_i),
    .coded_h_i     (coded_h_i),
    .left_o        (left_margin_o),
    .top_o         (top_margin_o),
    .x_shift_o     (source_x_shift_o),
    .y_shift_o     (source_y_shift_o),
    .width_o       (window_width_o),
    .height_o      (window_height_o),
    .pending_o     (win_pending)
  );

  // mode sequencing
  always_comb begin
    next_mode = mode;
    case (mode)
      playback_cmd_pkg::MODE_STEP: begin
        if (picture_done_i) next_mode = playback_cmd_pkg::MODE_PAUSED;
      end
      default: begin
        if (is_step) next_mode = playback_cmd_pkg::MODE_STEP;
        else if (is_slow) next_mode = playback_cmd_pkg::MODE_SLOW;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) mode <= playback_cmd_pkg::MODE_IDLE;
    else mode <= next_mode;
  end

  // vblank pin synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vb_meta <= 1'b0;
      vb_sync <= 1'b0;
      vb_last <= 1'b0;
    end else begin
      vb_meta <= vblank_i;
      vb_sync <= vb_meta;
      vb_last <= vb_sync;
    end
  end

  // set-type settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      video_stream_select_o <= `RST_VIDEO_ID;
      audio_stream_select_o <= `RST_AUDIO_ID;
    end else if (is_strm) begin
      video_stream_select_o <= cmd.arg[0];
      audio_stream_select_o <= cmd.arg[1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fmt           <= `FMT_NO_REPEAT;
      hcoeff        <= 16'h0000;
      interlace_sel <= 16'h0000;
    end else if (is_fmt) begin
      fmt           <= cmd.arg[0];
      hcoeff        <= cmd.arg[1];
      interlace_sel <= cmd.arg[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) event_enable_mask <= `RST_MASK;
    else if (is_mask) event_enable_mask <= cmd.arg[0];
    else if (wr_mask) event_enable_mask <= merge16(event_enable_mask, wb_dat_i[15:0],
                                                   wb_sel_i[1:0]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) vconfig <= `RST_VCONFIG;
    else if (wr_vcfg) vconfig <= merge16(vconfig, wb_dat_i[15:0], wb_sel_i[1:0]);
  end

  // slow motion repeat and input gating
  always_ff @(posedge clk_i) begin
    if (rst_i) slow_n <= `RST_SLOW_N;
    else if (is_slow) slow_n <= arg_n;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) rep_cnt <= 4'h0;
    else if (is_slow | slow_adv) rep_cnt <= 4'h0;
    else if (in_slow & frame_tick_i) rep_cnt <= rep_cnt + 4'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) slow_in_en <= 1'b1;
    else if (is_slow | slow_rdy) slow_in_en <= 1'b1;
    else if (slow_ful) slow_in_en <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) decode_next_o <= 1'b0;
    else decode_next_o <= is_step | is_slow | slow_adv;
  end

  // event status, set beats clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_status <= 16'h0000;
      int_o        <= 1'b0;
    end else begin
      event_status <= next_evt;
      int_o        <= |next_evt;
    end
  end

  // bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) ack <= 1'b0;
    else ack <= fire;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd) begin
      case (wb_adr_i)
        `REG_CMD:        wb_dat_o <= {28'h0000000, win_pending, ~accept, mode};
        `REG_EVT_STATUS: wb_dat_o <= {16'h0000, event_status};
        `REG_EVT_MASK:   wb_dat_o <= {16'h0000, event_enable_mask};
        `REG_VCONFIG:    wb_dat_o <= {16'h0000, vconfig};
        `REG_STREAMS:    wb_dat_o <= {audio_stream_select_o, video_stream_select_o};
        `REG_FORMAT:     wb_dat_o <= {16'h0000, fmt};
        `REG_HCOEFF:     wb_dat_o <= {16'h0000, hcoeff};
        `REG_INTERLACE:  wb_dat_o <= {16'h0000, interlace_sel};
        default:         wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  assign wb_ack_o = ack;

  // output gating from stream selection
  wire vid_ok = in_range(video_stream_select_o, `VID_ID_LO, `VID_ID_HI);
  wire aud_ok = in_range(audio_stream_select_o, `AUD_ID_LO, `AUD_ID_HI);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      video_out_en_o       <= 1'b0;
      audio_out_en_o       <= 1'b0;
      bitstream_input_en_o <= 1'b1;
    end else begin
      video_out_en_o       <= vid_ok;
      audio_out_en_o       <= aud_ok & ~in_step & ~in_slow &
                              (mode != playback_cmd_pkg::MODE_PAUSED);
      bitstream_input_en_o <= ~in_slow | slow_in_en;
    end
  end

  // format decode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      format_code_o        <= `FMT_NO_REPEAT;
      field_repeat_en_o    <= 1'b0;
      pal_o                <= 1'b0;
      ntsc_o               <= 1'b0;
      horiz_interp_coeff_o <= 16'h0000;
      horiz_interp_en_o    <= 1'b0;
      interlaced_o         <= 1'b0;
      vert_interp_o        <= `RST_VCONFIG;
    end else begin
      format_code_o        <= fmt;
      field_repeat_en_o    <= (fmt != `FMT_NO_REPEAT);
      pal_o                <= (fmt == `FMT_PAL);
      ntsc_o               <= (fmt == `FMT_NTSC);
      horiz_interp_coeff_o <= hcoeff;
      horiz_interp_en_o    <= (hcoeff != 16'h0000);
      interlaced_o         <= (interlace_sel != 16'h0000);
      vert_interp_o        <= vconfig;
    end
  end
endmodule
`default_nettype wire

//--- host_cmd_model.sv
// Purpose: host side, issues classic Wishbone cycles
// Assumes: xfer is entered just after a rising edge
// Notes:   released address and data lines show the inverse
`default_nettype none
module host_cmd_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'hf;
    dat_o = 32'h0000_0000;
  end
  // one cycle; q takes read data, to flags a missing ack
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic to);
    int k = 0;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_i !== 1'b1 && k < 200);
    q = dat_i;
    to = ack_i !== 1'b1;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- playback_cmd_chk.sv
// Purpose: port checks of the command handler
// Assumes: one clock, sync active-high reset
// Notes:   bind follows the module
`default_nettype none
`include "playback_cmd_map.svh"
module playback_cmd_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        vblank_i,
  input wire logic        picture_done_i,
  input wire logic        buffer_full_i,
  input wire logic        below_threshold_i,
  input wire logic [15:0] video_stream_select_o,
  input wire logic        video_out_en_o,
  input wire logic [15:0] format_code_o,
  input wire logic        field_repeat_en_o,
  input wire logic        pal_o,
  input wire logic        ntsc_o,
  input wire logic [15:0] vert_interp_o,
  input wire logic [15:0] left_margin_o,
  input wire logic [15:0] window_width_o,
  input wire logic        bitstream_input_en_o,
  input wire logic        int_o
);
  logic [3:0]  since_vb;
  logic [15:0] vcfg_q;
  wire         vid_ok = video_stream_select_o >= `VID_ID_LO
                        && video_stream_select_o <= `VID_ID_HI;
  wire         ev     = picture_done_i || buffer_full_i || below_threshold_i;
  wire         wr     = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  wire         wr_cfg = wr && wb_adr_i == `REG_VCONFIG;
  wire         wr_sts = wr && wb_adr_i == `REG_EVT_STATUS;
  always_ff @(posedge clk_i) begin
    if (rst_i) since_vb <= 4'hf;
    else if (vblank_i) since_vb <= 4'h0;
    else if (since_vb != 4'hf) since_vb <= since_vb + 4'h1;
    if (wr_cfg) vcfg_q <= wb_dat_i[15:0];
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_cfg_write;
    wr_cfg ##1 wb_ack_o;
  endsequence
  AST_ACK: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:16] wb_ack_o ##1 !wb_ack_o)
    else $error("bus cycle not answered");
  AST_VID_EN: assert property (
    !$past(rst_i) && $stable(video_stream_select_o) |-> video_out_en_o == vid_ok)
    else $error("video enable off its id");
  AST_FMT: assert property (
    !$past(rst_i) && $stable(format_code_o) |-> pal_o == (format_code_o == `FMT_PAL)
    && ntsc_o == (format_code_o == `FMT_NTSC)
    && field_repeat_en_o == (format_code_o != `FMT_NO_REPEAT))
    else $error("format flags off the code");
  AST_CFG: assert property (
    s_cfg_write |-> ##[0:2] vert_interp_o == vcfg_q)
    else $error("vertical setting not taken");
  AST_WIN: assert property (
    !$past(rst_i) && $changed({left_margin_o, window_width_o}) |-> since_vb <= 4'h4)
    else $error("window moved outside blanking");
  AST_FULL: assert property (
    $fell(bitstream_input_en_o) |-> buffer_full_i || $past(buffer_full_i, 2))
    else $error("input stopped without full");
  AST_REFILL: assert property (
    !$past(rst_i) && $rose(bitstream_input_en_o) |-> $past(below_threshold_i, 2))
    else $error("input resumed without low level");
  AST_IRQ_SET: assert property (
    !$past(rst_i) && $rose(int_o) |-> $past(ev) || $past(ev, 2) || $past(ev, 3))
    else $error("interrupt without event");
  AST_IRQ_CLR: assert property (
    !$past(rst_i) && $fell(int_o) |-> $past(wr_sts) || $past(wr_sts, 2))
    else $error("interrupt dropped without clear");
endmodule
bind playback_display_command_handler playback_cmd_chk i_playback_cmd_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .vblank_i(vblank_i), .picture_done_i(picture_done_i), .buffer_full_i(buffer_full_i),
  .below_threshold_i(below_threshold_i), .video_stream_select_o(video_stream_select_o),
  .video_out_en_o(video_out_en_o), .format_code_o(format_code_o),
  .field_repeat_en_o(field_repeat_en_o), .pal_o(pal_o), .ntsc_o(ntsc_o),
  .vert_interp_o(vert_interp_o), .left_margin_o(left_margin_o),
  .window_width_o(window_width_o), .bitstream_input_en_o(bitstream_input_en_o),
  .int_o(int_o)
);
`default_nettype wire

//--- playback_display_command_handler_test.sv
// Purpose: directed bench of the playback command handler
// Assumes: host model owns the bus, bench drives the video side
// Notes:   screen size set here feeds the centring figures
`default_nettype none
`include "playback_cmd_map.svh"
module playback_display_command_handler_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] SW = 16'd720;
  localparam logic [15:0] SH = 16'd240;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        vb = 1'b0;
  logic        ftick = 1'b0;
  logic        pdone = 1'b0;
  logic        full = 1'b0;
  logic        low = 1'b0;
  logic [15:0] cw = 16'h0160;
  logic [15:0] ch = 16'h0078;
  logic [15:0] fmts [3] = '{`FMT_NO_REPEAT, `FMT_PAL, `FMT_NTSC};
  logic [31:0] q;
  logic        to;
  int          n_fail = 0;
  int          n_tests = 0;
  int          npulse = 0;
  int          n0;
  wire         cyc, stb, we, ack, ven, aen, frep, pal, ntsc, hen, intl, dnext, inen, irq;
  wire  [7:0]  adr;
  wire  [3:0]  sel;
  wire  [31:0] wdat, rdat;
  wire  [15:0] vsel, asel, fmt, coeff, vcfg, lm, tm, xs, ys, ww, wh;
  always #2.5 clk_i = ~clk_i;
  always @(negedge clk_i) if (dnext === 1'b1) npulse++;
  host_cmd_model i_host_cmd_model (
    .clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  playback_display_command_handler #(.SCREEN_W(SW), .SCREEN_H(SH))
    i_playback_display_command_handler (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .vblank_i(vb), .frame_tick_i(ftick), .picture_done_i(pdone), .buffer_full_i(full),
    .below_threshold_i(low), .coded_w_i(cw), .coded_h_i(ch),
    .video_stream_select_o(vsel), .audio_stream_select_o(asel), .video_out_en_o(ven),
    .audio_out_en_o(aen), .format_code_o(fmt), .field_repeat_en_o(frep), .pal_o(pal),
    .ntsc_o(ntsc), .horiz_interp_coeff_o(coeff), .horiz_interp_en_o(hen),
    .interlaced_o(intl), .vert_interp_o(vcfg), .left_margin_o(lm), .top_margin_o(tm),
    .source_x_shift_o(xs), .source_y_shift_o(ys), .window_width_o(ww),
    .window_height_o(wh), .decode_next_o(dnext), .bitstream_input_en_o(inen),
    .int_o(irq));
  task automatic final_report();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_host_cmd_model.xfer(w, a, d, q, to);
    if (to) begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  // first argument sits in the highest slot
  task automatic send(input logic [15:0] id, input playback_cmd_pkg::args_t a, input int n);
    bus(1'b1, `REG_CMD, {16'h0000, id});
    for (int i = n - 1; i >= 0; i--) bus(1'b1, `REG_CMD, {16'h0000, a[i]});
    tick(4);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(2);
    chk({ven, aen, inen, irq}, 4'b1110);
    bus(1'b1, `REG_STREAMS, 32'hffff_ffff);
    rd(`REG_STREAMS, {`RST_AUDIO_ID, `RST_VIDEO_ID});
    rd(8'h20, 32'h0000_0000);
    bus(1'b1, `REG_VCONFIG, 32'h0000_1234);
    tick(3);
    chk(vcfg, 16'h1234);
    send(`CMD_SEL_STREAMS, {16'h0010, 16'h00c5}, 2);
    chk({ven, aen}, 2'b01);
    rd(`REG_STREAMS, 32'h00c5_0010);
    send(`CMD_SEL_STREAMS, {16'h00e3, 16'h00ff}, 2);
    chk({ven, aen, vsel, asel}, {2'b10, 32'h00e3_00ff});
    for (int i = 0; i < 3; i++) begin
      send(`CMD_VIDEO_FORMAT, {fmts[i], 16'(i), 16'(i & 1)}, 3);
      chk({fmt, frep, pal, ntsc}, {fmts[i], i != 0, i == 1, i == 2});
      chk({coeff, hen, intl}, {16'(i), i != 0, i == 1});
    end
    send(`CMD_WINDOW, {16'd10, 16'd20, 16'd3, 16'd4, 16'd100, 16'd50}, 6);
    chk({lm, ww}, 32'h0000_0000);
    vb <= 1'b1;
    tick(4);
    vb <= 1'b0;
    tick(4);
    chk({lm, tm, xs, ys}, {16'd10, 16'd20, 16'd3, 16'd4});
    chk({ww, wh}, {16'd100, 16'd50});
    send(`CMD_WINDOW, '0, 6);
    vb <= 1'b1;
    tick(4);
    vb <= 1'b0;
    tick(4);
    chk({lm, tm, ww, wh}, {(SW - cw) >> 1, (SH - ch) >> 1, cw, ch});
    send(`CMD_SEL_STREAMS, {16'h00e3, 16'h00c0}, 2);
    send(`CMD_EVENT_ENABLE, 16'h2400, 1);
    rd(`REG_EVT_MASK, 32'h0000_2400);
    n0 = npulse;
    send(`CMD_STEP, '0, 0);
    chk({npulse - n0, aen, ven}, {32'd1, 2'b01});
    pdone <= 1'b1;
    tick(1);
    pdone <= 1'b0;
    tick(4);
    chk(irq, 1'b1);
    rd(`REG_EVT_STATUS, 32'h0000_2000);
    bus(1'b1, `REG_EVT_STATUS, 32'h0000_2000);
    tick(3);
    chk(irq, 1'b0);
    send(`CMD_SLOW, 16'h0002, 1);
    tick(4);
    n0 = npulse;
    for (int t = 0; t < 32; t++) begin
      ftick <= t % 8 == 0;
      @(posedge clk_i);
    end
    chk({npulse - n0, aen}, {32'd2, 1'b0});
    full <= 1'b1;
    tick(4);
    chk({inen, irq}, 2'b01);
    rd(`REG_EVT_STATUS, 32'h0000_2000);
    full <= 1'b0;
    low <= 1'b1;
    tick(4);
    chk(inen, 1'b1);
    rd(`REG_EVT_STATUS, 32'h0000_2400);
    low <= 1'b0;
    bus(1'b1, `REG_EVT_STATUS, 32'h0000_2400);
    tick(3);
    chk(irq, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
